// *** hdl/mei_pkg.sv ***
// Purpose: shared constants and types of the motion-event interrupt block
// Assumes: 8-bit register space, one 20 MHz clock
// Notes:   every offset, field position, reset value and timing count lives here
package mei_pkg;

    // ------------------------------------------------------------------
    // clock and sample-rate timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    // duration step equals one sample period at each output data rate
    localparam int STEP_FAST_US = 2500;
    localparam int STEP_SLOW_US = 10000;
    localparam int SMP_FAST_CYCLES = STEP_FAST_US * CLK_PER_US;
    localparam int SMP_SLOW_CYCLES = STEP_SLOW_US * CLK_PER_US;
    localparam int DIV_W = 18;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_EV1_CFG = 8'h30;
    localparam logic [7:0] ADDR_EV1_SRC = 8'h31;
    localparam logic [7:0] ADDR_EV1_THS = 8'h32;
    localparam logic [7:0] ADDR_EV1_DUR = 8'h33;
    localparam logic [7:0] ADDR_EV2_CFG = 8'h34;
    localparam logic [7:0] ADDR_EV2_SRC = 8'h35;
    localparam logic [7:0] ADDR_EV2_THS = 8'h36;
    localparam logic [7:0] ADDR_EV2_DUR = 8'h37;
    localparam logic [7:0] ADDR_TAP_CFG = 8'h38;
    localparam logic [7:0] ADDR_TAP_SRC = 8'h39;
    localparam logic [7:0] ADDR_TAP_THS = 8'h3b;
    localparam logic [7:0] ADDR_CTRL = 8'h40;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h41;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h42;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h43;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_GEN_CFG = 8'h00;
    localparam logic [7:0] RST_EV1_THS = 8'h04;
    localparam logic [7:0] RST_EV2_THS = 8'h00;
    localparam logic [7:0] RST_DUR = 8'h00;
    localparam logic [7:0] RST_SRC = 8'h00;
    localparam logic [7:0] RST_TAP_CFG = 8'h00;
    localparam logic [7:0] RST_TAP_THS = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_SMP_FAST_BIT = 0;
    localparam int IRQ_EV1_BIT = 0;
    localparam int IRQ_EV2_BIT = 1;
    localparam int IRQ_TAP_BIT = 2;
    localparam int NUM_GEN = 2;
    localparam logic [7:0] DUR_MAX = 8'hff;

    // ------------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic combine_and_select;
        logic latch_request;
        logic z_high_enable;
        logic z_low_enable;
        logic y_high_enable;
        logic y_low_enable;
        logic x_high_enable;
        logic x_low_enable;
    } mei_gen_cfg_t;

    typedef struct packed {
        logic unused;
        logic interrupt_active;
        logic z_high_flag;
        logic z_low_flag;
        logic y_high_flag;
        logic y_low_flag;
        logic x_high_flag;
        logic x_low_flag;
    } mei_gen_src_t;

    typedef struct packed {
        logic count_down_mode;
        logic [6:0] event_threshold;
    } mei_gen_ths_t;

    typedef struct packed {
        logic unused;
        logic latch_request;
        logic [5:0] tap_enable;
    } mei_tap_cfg_t;

    typedef struct packed {
        logic unused;
        logic interrupt_active;
        logic [5:0] tap_flags;
    } mei_tap_src_t;

    typedef struct packed {
        logic [3:0] y_tap_threshold;
        logic [3:0] x_tap_threshold;
    } mei_tap_ths_t;

endpackage : mei_pkg

// *** hdl/mei_top.sv ***
// Purpose: two motion-event generators, tap flag logic and an interrupt summary
// Assumes: all inputs synchronous to ref_clk; tap pulses come from a tap detector
// Notes:   sample periods come from an internal divider enable, not a second clock
//
// What this block does
// - at 400 Hz rate each duration count is 2.5 ms, up to 637.5 ms.
// - at 100 Hz rate each duration count is 10 ms, up to 2.55 s.
// - duration counter freezes while latching and the event condition holds.
// - enabled axis events are ORed when combine bit is 0, ANDed when 1.
// - latch bit 1 holds request and flags until source read; 0 latches nothing.
// - enabled high event fires when axis magnitude exceeds the threshold.
// - enabled low event fires when axis magnitude is below the threshold.
// - source register shows six axis flags plus an active flag.
// - source read-only; reading clears it and the interrupt, allowing new capture.
// - 7-bit threshold resetting to 4 for event 1 and zero for event 2, count-down mode bit on top.
// - mode 0 resets counter when condition ends; mode 1 decrements it.
// - tap latch bit 1 holds tap request and flags until tap source read.
// - per axis tap output: none, single, double, or either, by enables.
// - tap source shows per-axis single and double flags plus active flag.
// - x and y tap thresholds share one register, 4 bits each, reset zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module mei_top #(
    parameter int FAST_PERIOD = mei_pkg::SMP_FAST_CYCLES,
    parameter int SLOW_PERIOD = mei_pkg::SMP_SLOW_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic signed [7:0] accel_x,
    input wire logic signed [7:0] accel_y,
    input wire logic signed [7:0] accel_z,
    input wire logic [2:0] tap_single,
    input wire logic [2:0] tap_double,
    output logic [3:0] x_tap_threshold,
    output logic [3:0] y_tap_threshold,
    output logic smp_tick,
    output logic event1_interrupt,
    output logic event2_interrupt,
    output logic tap_interrupt,
    output logic irq
);

    // ------------------------------------------------------------------
    // control register and output data rate divider
    // ------------------------------------------------------------------
    logic [7:0] ctrl;
    logic [mei_pkg::DIV_W-1:0] div_cnt;
    wire ctrl_wr = reg_wr && (reg_addr == mei_pkg::ADDR_CTRL);
    wire smp_fast = ctrl[mei_pkg::CTRL_SMP_FAST_BIT];
    // sample period sets the duration step: 2.5 ms fast, 10 ms slow
    wire [mei_pkg::DIV_W-1:0] div_last = smp_fast ?
        mei_pkg::DIV_W'(FAST_PERIOD - 1) :
        mei_pkg::DIV_W'(SLOW_PERIOD - 1);
    // >= guards a rate change that leaves the count past the new limit
    wire div_wrap = (div_cnt >= div_last);
    wire [mei_pkg::DIV_W-1:0] next_div_cnt = div_wrap ? '0 : div_cnt + 1'b1;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl <= mei_pkg::RST_CTRL;
        end else if (ctrl_wr) begin
            ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_cnt <= '0;
            smp_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            smp_tick <= div_wrap;
        end
    end

    // ------------------------------------------------------------------
    // axis magnitudes, taken once per sample period
    // ------------------------------------------------------------------
    // magnitude keeps -128 as 128, so the unsigned compare stays exact
    wire [7:0] mag_x = accel_x[7] ? 8'(-accel_x) : 8'(accel_x);
    wire [7:0] mag_y = accel_y[7] ? 8'(-accel_y) : 8'(accel_y);
    wire [7:0] mag_z = accel_z[7] ? 8'(-accel_z) : 8'(accel_z);

    // ------------------------------------------------------------------
    // motion-event generators
    // ------------------------------------------------------------------
    logic [mei_pkg::NUM_GEN-1:0][7:0] gen_cfg_rd;
    logic [mei_pkg::NUM_GEN-1:0][7:0] gen_src_rd;
    logic [mei_pkg::NUM_GEN-1:0][7:0] gen_ths_rd;
    logic [mei_pkg::NUM_GEN-1:0][7:0] gen_dur_rd;
    logic [mei_pkg::NUM_GEN-1:0] gen_irq;

    for (genvar g = 0; g < mei_pkg::NUM_GEN; g++) begin : gen_event
        localparam logic [7:0] CFG_A = (g == 0) ? mei_pkg::ADDR_EV1_CFG : mei_pkg::ADDR_EV2_CFG;
        localparam logic [7:0] SRC_A = (g == 0) ? mei_pkg::ADDR_EV1_SRC : mei_pkg::ADDR_EV2_SRC;
        localparam logic [7:0] THS_A = (g == 0) ? mei_pkg::ADDR_EV1_THS : mei_pkg::ADDR_EV2_THS;
        localparam logic [7:0] DUR_A = (g == 0) ? mei_pkg::ADDR_EV1_DUR : mei_pkg::ADDR_EV2_DUR;
        localparam logic [7:0] THS_RST = (g == 0) ? mei_pkg::RST_EV1_THS : mei_pkg::RST_EV2_THS;

        mei_pkg::mei_gen_cfg_t cfg;
        mei_pkg::mei_gen_ths_t ths;
        mei_pkg::mei_gen_src_t src;
        logic [7:0] dur;
        logic [7:0] cnt;

        wire cfg_wr = reg_wr && (reg_addr == CFG_A);
        wire ths_wr = reg_wr && (reg_addr == THS_A);
        wire dur_wr = reg_wr && (reg_addr == DUR_A);
        // writes to the source address are ignored: it is read-only
        wire src_rd = reg_rd && (reg_addr == SRC_A);

        wire [7:0] lim = {1'b0, ths.event_threshold};
        wire [5:0] raw_ev = {
            mag_z > lim, mag_z < lim,
            mag_y > lim, mag_y < lim,
            mag_x > lim, mag_x < lim
        };
        wire [5:0] en = cfg[5:0];
        wire [5:0] ev = raw_ev & en;
        // and-mode with nothing enabled never fires
        wire cond_and = (|en) && (ev == en);
        wire cond = cfg.combine_and_select ? cond_and : (|ev);
        wire held = cfg.latch_request && src.interrupt_active && cond;
        wire fire = cond && (cnt >= dur);
        wire capture = smp_tick && fire && !(cfg.latch_request && src.interrupt_active);

        logic [7:0] next_cnt;
        mei_pkg::mei_gen_src_t next_src;

        always_comb begin
            next_cnt = cnt;
            if (smp_tick) begin
                if (held) begin
                    next_cnt = cnt;
                end else if (cond) begin
                    next_cnt = (cnt == mei_pkg::DUR_MAX) ? cnt : cnt + 8'h01;
                end else if (ths.count_down_mode) begin
                    next_cnt = (cnt == 8'h00) ? cnt : cnt - 8'h01;
                end else begin
                    next_cnt = 8'h00;
                end
            end
        end

        always_comb begin
            next_src = src;
            if (capture) begin
                // a capture in the cycle of the read wins over the clear
                next_src = {1'b0, 1'b1, ev};
            end else if (smp_tick && !cfg.latch_request) begin
                next_src = mei_pkg::RST_SRC;
            end else if (src_rd) begin
                next_src = mei_pkg::RST_SRC;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                cfg <= mei_pkg::RST_GEN_CFG;
                ths <= THS_RST;
                dur <= mei_pkg::RST_DUR;
                cnt <= 8'h00;
                src <= mei_pkg::RST_SRC;
            end else begin
                if (cfg_wr) begin
                    cfg <= reg_wdata;
                end
                if (ths_wr) begin
                    ths <= reg_wdata;
                end
                if (dur_wr) begin
                    dur <= reg_wdata;
                end
                cnt <= next_cnt;
                src <= next_src;
            end
        end

        // each generator owns its slice only
        assign gen_cfg_rd[g] = cfg;
        assign gen_src_rd[g] = src;
        assign gen_ths_rd[g] = ths;
        assign gen_dur_rd[g] = dur;
        assign gen_irq[g] = src.interrupt_active;
    end

    assign event1_interrupt = gen_irq[0];
    assign event2_interrupt = gen_irq[1];

    // ------------------------------------------------------------------
    // tap flags
    // ------------------------------------------------------------------
    mei_pkg::mei_tap_cfg_t tap_cfg;
    mei_pkg::mei_tap_src_t tap_src;
    mei_pkg::mei_tap_ths_t tap_ths;
    mei_pkg::mei_tap_src_t next_tap_src;

    wire tap_cfg_wr = reg_wr && (reg_addr == mei_pkg::ADDR_TAP_CFG);
    wire tap_ths_wr = reg_wr && (reg_addr == mei_pkg::ADDR_TAP_THS);
    wire tap_src_rd = reg_rd && (reg_addr == mei_pkg::ADDR_TAP_SRC);
    // order per axis: double then single, z down to x
    wire [5:0] tap_raw = {
        tap_double[2], tap_single[2],
        tap_double[1], tap_single[1],
        tap_double[0], tap_single[0]
    };
    wire [5:0] tap_ev = tap_raw & tap_cfg.tap_enable;
    wire tap_hit = |tap_ev;
    wire tap_hold = tap_cfg.latch_request && tap_src.interrupt_active;

    always_comb begin
        next_tap_src = tap_src;
        if (tap_hit && !tap_hold) begin
            next_tap_src = {1'b0, 1'b1, tap_ev};
        end else if (tap_src_rd) begin
            next_tap_src = mei_pkg::RST_SRC;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tap_cfg <= mei_pkg::RST_TAP_CFG;
            tap_ths <= mei_pkg::RST_TAP_THS;
            tap_src <= mei_pkg::RST_SRC;
        end else begin
            if (tap_cfg_wr) begin
                tap_cfg <= reg_wdata;
            end
            if (tap_ths_wr) begin
                tap_ths <= reg_wdata;
            end
            tap_src <= next_tap_src;
        end
    end

    assign x_tap_threshold = tap_ths.x_tap_threshold;
    assign y_tap_threshold = tap_ths.y_tap_threshold;
    assign tap_interrupt = tap_src.interrupt_active;

    // ------------------------------------------------------------------
    // interrupt summary: sticky rising-edge status, enable, clear
    // ------------------------------------------------------------------
    logic [2:0] line_prev;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    wire [2:0] lines = {tap_interrupt, event2_interrupt, event1_interrupt};
    wire [2:0] line_rise = lines & ~line_prev;
    wire irq_clr_wr = reg_wr && (reg_addr == mei_pkg::ADDR_IRQ_CLEAR);
    wire irq_en_wr = reg_wr && (reg_addr == mei_pkg::ADDR_IRQ_ENABLE);
    wire [2:0] clr_mask = irq_clr_wr ? reg_wdata[2:0] : 3'h0;
    // set wins: an edge in the cycle of its clear is kept
    wire [2:0] next_irq_status = (irq_status & ~clr_mask) | line_rise;
    wire [2:0] next_irq_enable = irq_en_wr ? reg_wdata[2:0] : irq_enable;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            line_prev <= mei_pkg::RST_IRQ;
            irq_status <= mei_pkg::RST_IRQ;
            irq_enable <= mei_pkg::RST_IRQ;
            irq <= 1'b0;
        end else begin
            line_prev <= lines;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq <= |(next_irq_status & next_irq_enable);
        end
    end

    // ------------------------------------------------------------------
    // register read port: data one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            mei_pkg::ADDR_EV1_CFG: rd_mux = gen_cfg_rd[0];
            mei_pkg::ADDR_EV1_SRC: rd_mux = gen_src_rd[0];
            mei_pkg::ADDR_EV1_THS: rd_mux = gen_ths_rd[0];
            mei_pkg::ADDR_EV1_DUR: rd_mux = gen_dur_rd[0];
            mei_pkg::ADDR_EV2_CFG: rd_mux = gen_cfg_rd[1];
            mei_pkg::ADDR_EV2_SRC: rd_mux = gen_src_rd[1];
            mei_pkg::ADDR_EV2_THS: rd_mux = gen_ths_rd[1];
            mei_pkg::ADDR_EV2_DUR: rd_mux = gen_dur_rd[1];
            mei_pkg::ADDR_TAP_CFG: rd_mux = tap_cfg;
            mei_pkg::ADDR_TAP_SRC: rd_mux = tap_src;
            mei_pkg::ADDR_TAP_THS: rd_mux = tap_ths;
            mei_pkg::ADDR_CTRL: rd_mux = ctrl;
            mei_pkg::ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_status};
            mei_pkg::ADDR_IRQ_ENABLE: rd_mux = {5'h00, irq_enable};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule : mei_top

// *** verification/mei_chk_assertions.sv ***
// Purpose: port-level checks of the motion-event interrupt block
// Assumes: one clock domain, srst synchronous and active high
// Notes:   sees only the ports of mei_top; attached by the bind at the foot
`timescale 1ns/1ps

module mei_chk #(
    parameter int FAST_PERIOD = 20,
    parameter int SLOW_PERIOD = 80
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic signed [7:0] accel_x,
    input wire logic signed [7:0] accel_y,
    input wire logic signed [7:0] accel_z,
    input wire logic [2:0] tap_single,
    input wire logic [2:0] tap_double,
    input wire logic [3:0] x_tap_threshold,
    input wire logic [3:0] y_tap_threshold,
    input wire logic smp_tick,
    input wire logic event1_interrupt,
    input wire logic event2_interrupt,
    input wire logic tap_interrupt,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // a capture on a tick edge wins over a read in that same cycle
    wire ev1_rd = reg_rd && reg_addr == mei_pkg::ADDR_EV1_SRC;
    wire ev2_rd = reg_rd && reg_addr == mei_pkg::ADDR_EV2_SRC;
    wire tap_rd = reg_rd && reg_addr == mei_pkg::ADDR_TAP_SRC;
    wire ths_wr = reg_wr && reg_addr == mei_pkg::ADDR_TAP_THS;
    wire any_tap = |(tap_single | tap_double);

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_tick_gap: assert property (smp_tick |=> !smp_tick [*8])
        else $error("sample ticks too close together");
    a_ev2_read_clear: assert property (ev2_rd && !smp_tick |=> !event2_interrupt)
        else $error("event2 interrupt survives a source read");
    a_ev1_read_clear: assert property (ev1_rd && !smp_tick |=> !event1_interrupt)
        else $error("event1 interrupt survives a source read");
    a_ev2_rise_tick: assert property ($rose(event2_interrupt) |-> $past(smp_tick))
        else $error("event2 interrupt rose without a sample tick");
    a_ev2_fall_cause: assert property ($fell(event2_interrupt) |->
        $past(smp_tick) || $past(ev2_rd))
        else $error("event2 interrupt fell without tick or read");
    a_tap_read_clear: assert property (tap_rd && !any_tap |=> !tap_interrupt)
        else $error("tap interrupt survives a source read");
    a_tap_rise_cause: assert property ($rose(tap_interrupt) |-> $past(any_tap))
        else $error("tap interrupt rose without a tap pulse");
    a_ths_follow: assert property ($changed({y_tap_threshold, x_tap_threshold}) |->
        $past(ths_wr) || $past(ths_wr, 2))
        else $error("tap threshold changed without a write");

    c_ev2_fire: cover property ($rose(event2_interrupt));
    c_tap_fire: cover property ($rose(tap_interrupt));
    c_irq_rise: cover property ($rose(irq));
endmodule : mei_chk

bind mei_top mei_chk #(.FAST_PERIOD(FAST_PERIOD), .SLOW_PERIOD(SLOW_PERIOD)) u_mei_chk (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .accel_x(accel_x),
    .accel_y(accel_y), .accel_z(accel_z), .tap_single(tap_single),
    .tap_double(tap_double), .x_tap_threshold(x_tap_threshold),
    .y_tap_threshold(y_tap_threshold), .smp_tick(smp_tick),
    .event1_interrupt(event1_interrupt), .event2_interrupt(event2_interrupt),
    .tap_interrupt(tap_interrupt), .irq(irq)
);

// *** verification/mei_host_model.sv ***
// Purpose: host side of the register port, reads and writes on request
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes:   write data is inverted once released so stale values never match
`timescale 1ns/1ps

module mei_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : rd
endmodule : mei_host_model

// *** verification/mei_top_tb.sv ***
// Purpose: self-checking bench of the motion-event interrupt block
// Assumes: shortened sample periods, host model on the register port
// Notes:   expected source values come from an integer model of the generator
`timescale 1ns/1ps

module mei_top_tb;
    localparam int FAST = 20;
    localparam int SLOW = 80;
    logic ref_clk;
    logic srst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, t, e;
    logic reg_wr, reg_rd, smp_tick, event1_interrupt, event2_interrupt, tap_interrupt, irq;
    logic signed [7:0] accel_x, accel_y, accel_z;
    logic [2:0] tap_single, tap_double;
    logic [3:0] x_tap_threshold, y_tap_threshold;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    logic [7:0] rst_addr [10] = '{8'h35, 8'h39, 8'h50, 8'h33, 8'h34, 8'h36, 8'h37, 8'h38, 8'h3b,
        8'h31};

    mei_top #(.FAST_PERIOD(FAST), .SLOW_PERIOD(SLOW)) dut (
        .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .accel_x(accel_x),
        .accel_y(accel_y), .accel_z(accel_z), .tap_single(tap_single),
        .tap_double(tap_double), .x_tap_threshold(x_tap_threshold),
        .y_tap_threshold(y_tap_threshold), .smp_tick(smp_tick),
        .event1_interrupt(event1_interrupt), .event2_interrupt(event2_interrupt),
        .tap_interrupt(tap_interrupt), .irq(irq)
    );
    mei_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------------
    // model and helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] gen_model(input logic [7:0] cfg, input logic [6:0] ths,
        input logic signed [7:0] ax, input logic signed [7:0] ay, input logic signed [7:0] az);
        int a[3];
        logic [5:0] ev;
        logic cond;
        a = '{int'(ax), int'(ay), int'(az)};
        for (int i = 0; i < 3; i++) begin
            a[i] = a[i] < 0 ? -a[i] : a[i];
            ev[2*i+1] = a[i] > int'(ths);
            ev[2*i] = a[i] < int'(ths);
        end
        ev = ev & cfg[5:0];
        cond = cfg[7] ? (cfg[5:0] != 6'h00 && ev == cfg[5:0]) : ev != 6'h00;
        return cond ? {2'b01, ev} : 8'h00;
    endfunction : gen_model

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] x;
        host.rd(a, x);
        chk($sformatf("register %h", a), exp, x);
    endtask : rdchk

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk iff smp_tick === 1'b1);
    endtask : tick

    task automatic pulse(input logic [2:0] s, input logic [2:0] d);
        @(posedge ref_clk);
        tap_single <= s;
        tap_double <= d;
        @(posedge ref_clk);
        tap_single <= 3'h0;
        tap_double <= 3'h0;
        repeat (2) @(posedge ref_clk);
    endtask : pulse

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // a hang costs one mismatch and still reaches the verdict
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_fail++;
            $display("[ERR] timeout expected done seen running");
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        {accel_x, accel_y, accel_z} = 24'h0000_00;
        tap_single = 3'h0;
        tap_double = 3'h0;
        void'($urandom(32'h0597));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) host.wr(rst_addr[i], 8'hff);
        foreach (rst_addr[i]) rdchk(rst_addr[i], 8'h00);
        rdchk(8'h32, 8'h04);
        v = 8'($urandom);
        host.wr(8'h3b, v);
        rdchk(8'h3b, v);
        chk("tap thresholds", v, {y_tap_threshold, x_tap_threshold});
        for (int i = 0; i < 2; i++) begin
            host.wr(8'h40, 8'(i));
            tick(2);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (smp_tick !== 1'b1);
            chk("sample period", 8'(i ? FAST : SLOW), 8'(n));
        end
        host.wr(8'h37, 8'h02);
        host.wr(8'h34, 8'h02);
        for (int m = 0; m < 2; m++) begin
            host.wr(8'h36, {m[0], 7'h10});
            accel_x <= 8'h00;
            tick(4);
            accel_x <= 8'h40;
            tick(2);
            repeat (2) @(posedge ref_clk);
            chk("event2 early", 8'h00, {7'h00, event2_interrupt});
            accel_x <= 8'h00;
            tick(1);
            accel_x <= 8'h40;
            tick(2);
            repeat (2) @(posedge ref_clk);
            chk("event2 after gap", 8'(m), {7'h00, event2_interrupt});
            tick(1);
            repeat (2) @(posedge ref_clk);
            chk("event2 fired", 8'h01, {7'h00, event2_interrupt});
            chk("event1 idle", 8'h00, {7'h00, event1_interrupt});
        end
        host.wr(8'h37, 8'h00);
        repeat (10) begin
            v = {1'($urandom), 1'b0, 6'($urandom)};
            t = {1'b0, 7'($urandom)};
            host.wr(8'h34, v);
            host.wr(8'h36, t);
            accel_x <= 8'($urandom);
            accel_y <= 8'($urandom);
            accel_z <= 8'($urandom);
            tick(2);
            e = gen_model(v, t[6:0], accel_x, accel_y, accel_z);
            rdchk(8'h35, e);
        end
        host.wr(8'h34, 8'h00);
        tick(2);
        host.wr(8'h42, 8'h07);
        host.wr(8'h43, 8'h02);
        host.wr(8'h36, 8'h10);
        host.wr(8'h34, 8'h42);
        accel_x <= 8'h40;
        tick(2);
        accel_x <= 8'h00;
        tick(2);
        repeat (2) @(posedge ref_clk);
        chk("event2 held", 8'h01, {7'h00, event2_interrupt});
        chk("irq", 8'h01, {7'h00, irq});
        rdchk(8'h41, 8'h02);
        rdchk(8'h35, 8'h42);
        rdchk(8'h35, 8'h00);
        chk("event2 cleared", 8'h00, {7'h00, event2_interrupt});
        for (int i = 0; i < 3; i++) begin
            host.wr(i == 2 ? 8'h42 : 8'h43, i == 0 ? 8'h00 : 8'h02);
            repeat (3) @(posedge ref_clk);
            chk("irq mask", 8'(i == 1), {7'h00, irq});
        end
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h38, 8'(m));
            pulse(3'h1, 3'h0);
            rdchk(8'h39, m[0] ? 8'h41 : 8'h00);
            pulse(3'h0, 3'h1);
            rdchk(8'h39, m[1] ? 8'h42 : 8'h00);
        end
        host.wr(8'h38, 8'h4c);
        pulse(3'h2, 3'h0);
        pulse(3'h0, 3'h2);
        chk("tap held", 8'h01, {7'h00, tap_interrupt});
        rdchk(8'h39, 8'h44);
        rdchk(8'h39, 8'h00);
        test_done();
    end
endmodule : mei_top_tb
